//--- verilog/shra_defines.vh
/*
 Constants for the two-wire/four-wire serial register access front end.
 Assumes inclusion by its bare name from the design module.
*/
`ifndef SHRA_DEFINES_VH
`define SHRA_DEFINES_VH
// ****************************************************************
// Strap codes (synchronised strap level decode)
// ****************************************************************
`define SHRA_STRAP_VDD      2'h0
`define SHRA_STRAP_VSS      2'h1
`define SHRA_STRAP_SCL      2'h2
`define SHRA_STRAP_SDA      2'h3
// ****************************************************************
// Address map (7-bit values)
// ****************************************************************
`define SHRA_ADDR_BASE_VDD  7'h48
`define SHRA_ADDR_BASE_VSS  7'h4C
`define SHRA_ADDR_BASE_SCL  7'h50
`define SHRA_ADDR_BASE_SDA  7'h54
`define SHRA_ADDR_STEP_VDD  7'h00
`define SHRA_ADDR_STEP_VSS  7'h01
`define SHRA_ADDR_STEP_SCL  7'h02
`define SHRA_ADDR_STEP_SDA  7'h03
// ****************************************************************
// Register address byte fields
// ****************************************************************
`define SHRA_DIR_BIT        7
`define SHRA_REG_MSB        6
`define SHRA_REG_LSB        3
`define SHRA_CH_MSB         2
`define SHRA_CH_LSB         1
`define SHRA_DIR_READ       1'h1
`define SHRA_DIR_WRITE      1'h0
`define SHRA_CH_ZERO        2'h0
`endif

//--- verilog/shra_serial_host_register_access.v
/*
 Two-wire slave front end: address decode, subaddress, register write and
 read byte sequencing, and four-wire register address byte decode.
 Assumes all bus pins and straps are asynchronous to CLK_IN (sampled by two
 flops), the link clock is far slower than CLK_IN, and the register file
 answers RD_DATA_IN in the cycle after a read strobe.
 Assumes an external pull-up on the data line: the block only ever pulls
 it low, through SDA_OE_OUT, and SDA_OUT stays at zero.
 Assumes the bus clock low time spans at least four CLK_IN cycles, so
 that a bit driven after a falling clock edge settles before the next
 rising edge.
*/
// Notes on behaviour
// - Slave address comes from two four-state straps: high picks 0x90/0x98/0xA0/0xA8, low adds 0/2/4/6.
// - Address byte bit 0 is 0 for write and 1 for read, upper seven bits are the address.
// - Reset clears the decoder and holds it idle until a valid START.
// - After START the decoder samples clock, data and straps; the STOP edge resets it.
// - The decoder resets at every STOP and restarts at every START, never locking.
// - The byte after the address is an 8-bit subaddress that the device acknowledges.
// - Two-wire subaddress bits 6:3 select the register and bits 2:1 the channel; 7 and 0 ignored.
// - A write cycle writes each data byte in turn to the subaddressed location.
// - A read cycle uses repeated START with read direction; master ACKs all but the last byte.
// - Four-wire address byte bit 7 is direction (1 read), 6:3 register, 2:1 channel.
// - START is data falling with clock high, STOP is data rising with clock high.
`timescale 1ns/100ps
`include "shra_defines.vh"

module shra_serial_host_register_access (
   // Clock and reset
   input  wire       CLK_IN,
   input  wire       RESETN_IN,
   // Two-wire bus
   input  wire       SCL_IN,
   input  wire       SDA_IN,
   output reg        SDA_OUT,
   output reg        SDA_OE_OUT,
   // Address straps: 0 supply, 1 ground, 2 tied to clock, 3 tied to data
   input  wire [1:0] ADDR_STRAP_HIGH_IN,
   input  wire [1:0] ADDR_STRAP_LOW_IN,
   // Four-wire register address byte, decoded when strobed
   input  wire       SPI_ADDR_VALID_IN,
   input  wire [7:0] SPI_ADDR_BYTE_IN,
   output reg        SPI_READ_OUT,
   output reg  [3:0] SPI_REG_SEL_OUT,
   output reg  [1:0] SPI_CHANNEL_OUT,
   output reg        SPI_CH_ERR_OUT,
   // Register file side
   output reg        WR_STB_OUT,
   output reg        RD_STB_OUT,
   output reg  [3:0] REG_SEL_OUT,
   output reg  [1:0] CHANNEL_OUT,
   output reg  [7:0] WR_DATA_OUT,
   input  wire [7:0] RD_DATA_IN,
   // Status
   output reg        ADDRESSED_OUT,
   output reg        BUSY_OUT
);

   // ****************************************************************
   // States
   // ****************************************************************
   // One-hot, so each state test is a single flop
   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_ADDR = 7'h02;
   localparam [6:0] ST_SUB  = 7'h04;
   localparam [6:0] ST_WDAT = 7'h08;
   localparam [6:0] ST_RDAT = 7'h10;
   localparam [6:0] ST_MACK = 7'h20;
   localparam [6:0] ST_IGN  = 7'h40;

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   // Bus pins pass two flops; a third flop only serves edge detection.
   // All three reset to the idle high level, so the first cycles after
   // reset cannot show a false START, STOP or clock edge.
   reg        scl_s1_reg;
   reg        scl_s2_reg;
   reg        scl_q_reg;
   reg        sda_s1_reg;
   reg        sda_s2_reg;
   reg        sda_q_reg;
   reg  [1:0] sh_s1_reg;
   reg  [1:0] sl_s1_reg;
   reg  [1:0] sh_reg;
   reg  [1:0] sl_reg;
   wire       scl = scl_s2_reg;
   wire       sda = sda_s2_reg;

   always @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         scl_q_reg  <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         sda_q_reg  <= 1'b1;
      end else begin
         scl_s1_reg <= SCL_IN;
         scl_s2_reg <= scl_s1_reg;
         scl_q_reg  <= scl_s2_reg;
         sda_s1_reg <= SDA_IN;
         sda_s2_reg <= sda_s1_reg;
         sda_q_reg  <= sda_s2_reg;
      end
   end

   // Straps are static levels; a change takes effect two cycles later
   always @(posedge CLK_IN) begin
      sh_s1_reg <= ADDR_STRAP_HIGH_IN;
      sl_s1_reg <= ADDR_STRAP_LOW_IN;
      sh_reg    <= sh_s1_reg;
      sl_reg    <= sl_s1_reg;
   end

   // ****************************************************************
   // Bus conditions
   // ****************************************************************
   // START and STOP need the clock high in both samples
   wire scl_rise = scl & ~scl_q_reg;
   wire scl_fall = ~scl & scl_q_reg;
   wire start_c  = scl & scl_q_reg & sda_q_reg & ~sda;
   wire stop_c   = scl & scl_q_reg & ~sda_q_reg & sda;

   // ****************************************************************
   // Strap address decode
   // ****************************************************************
   reg [6:0] addr_base;
   reg [6:0] addr_step;
   reg [6:0] my_addr;
   always @* begin
      case (sh_reg)
         `SHRA_STRAP_VDD: addr_base = `SHRA_ADDR_BASE_VDD;
         `SHRA_STRAP_VSS: addr_base = `SHRA_ADDR_BASE_VSS;
         `SHRA_STRAP_SCL: addr_base = `SHRA_ADDR_BASE_SCL;
         default:         addr_base = `SHRA_ADDR_BASE_SDA;
      endcase
      case (sl_reg)
         `SHRA_STRAP_VDD: addr_step = `SHRA_ADDR_STEP_VDD;
         `SHRA_STRAP_VSS: addr_step = `SHRA_ADDR_STEP_VSS;
         `SHRA_STRAP_SCL: addr_step = `SHRA_ADDR_STEP_SCL;
         default:         addr_step = `SHRA_ADDR_STEP_SDA;
      endcase
      // Never carries past bit 6: largest base plus step is the map's top
      my_addr = addr_base + addr_step;
   end

   // ****************************************************************
   // Byte engine
   // ****************************************************************
   reg [6:0] state_reg;
   reg [7:0] shift_reg;
   reg [3:0] bit_cnt_reg;
   reg       ack_phase_reg;
   reg       rd_pend_reg;
   reg [7:0] tx_reg;

   // Transmitted bytes are counted on falling edges only, so the
   // receive counter must stay idle while the device is sending
   wire rx_state = (state_reg != ST_IDLE) && (state_reg != ST_RDAT)
                   && (state_reg != ST_MACK);

   always @(posedge CLK_IN) begin
      WR_STB_OUT <= 1'b0;
      RD_STB_OUT <= 1'b0;
      if (!RESETN_IN) begin
         state_reg     <= ST_IDLE;
         shift_reg     <= 8'h00;
         bit_cnt_reg   <= 4'h0;
         ack_phase_reg <= 1'b0;
         rd_pend_reg   <= 1'b0;
         tx_reg        <= 8'h00;
         SDA_OUT       <= 1'b0;
         SDA_OE_OUT    <= 1'b0;
         REG_SEL_OUT   <= 4'h0;
         CHANNEL_OUT   <= 2'h0;
         WR_DATA_OUT   <= 8'h00;
         ADDRESSED_OUT <= 1'b0;
         BUSY_OUT      <= 1'b0;
      end else if (stop_c) begin
         state_reg     <= ST_IDLE;
         SDA_OE_OUT    <= 1'b0;
         ADDRESSED_OUT <= 1'b0;
         BUSY_OUT      <= 1'b0;
         ack_phase_reg <= 1'b0;
      end else if (start_c) begin
         // Repeated START keeps the subaddress pointer
         state_reg     <= ST_ADDR;
         bit_cnt_reg   <= 4'h0;
         ack_phase_reg <= 1'b0;
         SDA_OE_OUT    <= 1'b0;
         ADDRESSED_OUT <= 1'b0;
         BUSY_OUT      <= 1'b1;
      end else if (rd_pend_reg) begin
         // Register data arrives one cycle after the strobe; the line is
         // left alone here, as the clock may be high and the first bit
         // goes out only at the next falling edge
         rd_pend_reg <= 1'b0;
         tx_reg      <= RD_DATA_IN;
      end else if (scl_rise && !ack_phase_reg && rx_state) begin
         // Sample on rising clock; byte is MSB first
         shift_reg   <= {shift_reg[6:0], sda};
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (scl_rise && ack_phase_reg && state_reg == ST_MACK) begin
         // Master NACK ends the read; its ACK fetches the next byte
         if (sda)
            state_reg <= ST_IGN;
         else begin
            state_reg   <= ST_RDAT;
            RD_STB_OUT  <= 1'b1;
            rd_pend_reg <= 1'b1;
         end
      end else if (scl_fall) begin
         if (ack_phase_reg) begin
            ack_phase_reg <= 1'b0;
            bit_cnt_reg   <= 4'h0;
            SDA_OE_OUT    <= 1'b0;
            if (state_reg == ST_RDAT) begin
               SDA_OE_OUT  <= ~tx_reg[7];
               tx_reg      <= {tx_reg[6:0], 1'b0};
               bit_cnt_reg <= 4'h1;
            end
         end else if (state_reg == ST_RDAT || state_reg == ST_MACK) begin
            // Device transmits: bits change on the falling clock only
            if (bit_cnt_reg == 4'h8) begin
               // Release for master acknowledge
               SDA_OE_OUT    <= 1'b0;
               state_reg     <= ST_MACK;
               ack_phase_reg <= 1'b1;
            end else begin
               SDA_OE_OUT  <= ~tx_reg[7];
               tx_reg      <= {tx_reg[6:0], 1'b0};
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
         end else if (bit_cnt_reg == 4'h8) begin
            ack_phase_reg <= 1'b1;
            case (state_reg)
               ST_ADDR: begin
                  if (shift_reg[7:1] == my_addr) begin
                     SDA_OE_OUT    <= 1'b1;
                     ADDRESSED_OUT <= 1'b1;
                     if (shift_reg[0] == `SHRA_DIR_READ) begin
                        state_reg   <= ST_RDAT;
                        RD_STB_OUT  <= 1'b1;
                        rd_pend_reg <= 1'b1;
                     end else
                        state_reg <= ST_SUB;
                  end else
                     state_reg <= ST_IGN;
               end
               ST_SUB: begin
                  // Bits 7 and 0 of the subaddress are ignored
                  SDA_OE_OUT  <= 1'b1;
                  REG_SEL_OUT <= shift_reg[`SHRA_REG_MSB:`SHRA_REG_LSB];
                  CHANNEL_OUT <= shift_reg[`SHRA_CH_MSB:`SHRA_CH_LSB];
                  state_reg   <= ST_WDAT;
               end
               ST_WDAT: begin
                  // Pointer is kept, so every byte lands at one register
                  SDA_OE_OUT  <= 1'b1;
                  WR_DATA_OUT <= shift_reg;
                  WR_STB_OUT  <= 1'b1;
               end
               ST_IGN: begin
                  // Not addressed: line stays released until START or STOP
                  SDA_OE_OUT <= 1'b0;
               end
               default: begin
                  SDA_OE_OUT <= 1'b0;
                  state_reg  <= ST_IGN;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Four-wire register address byte decode
   // ****************************************************************
   // Fields are taken only on the strobe and held until the next one
   wire [1:0] spi_ch_field = SPI_ADDR_BYTE_IN[`SHRA_CH_MSB:`SHRA_CH_LSB];

   always @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         SPI_READ_OUT    <= 1'b0;
         SPI_REG_SEL_OUT <= 4'h0;
         SPI_CHANNEL_OUT <= 2'h0;
         SPI_CH_ERR_OUT  <= 1'b0;
      end else if (SPI_ADDR_VALID_IN) begin
         SPI_READ_OUT    <= SPI_ADDR_BYTE_IN[`SHRA_DIR_BIT];
         SPI_REG_SEL_OUT <= SPI_ADDR_BYTE_IN[`SHRA_REG_MSB:`SHRA_REG_LSB];
         SPI_CHANNEL_OUT <= spi_ch_field;
         // Reserved channel codes flagged, not acted on
         SPI_CH_ERR_OUT  <= (spi_ch_field != `SHRA_CH_ZERO);
      end
   end

endmodule // shra_serial_host_register_access

//--- sim/shra_checker_sva.sv
/* Port-level checker for the serial register access front end.
   Assumes binding to the top module; bus pins change between clock edges. */
`timescale 1ns/100ps
module shra_checker (
   // Clock, reset and bus pins
   input wire       CLK_IN,
   input wire       RESETN_IN,
   input wire       SCL_IN,
   input wire       SDA_IN,
   input wire       SDA_OUT,
   input wire       SDA_OE_OUT,
   // Four-wire address byte
   input wire       SPI_ADDR_VALID_IN,
   input wire [7:0] SPI_ADDR_BYTE_IN,
   input wire       SPI_READ_OUT,
   input wire [3:0] SPI_REG_SEL_OUT,
   input wire [1:0] SPI_CHANNEL_OUT,
   input wire       SPI_CH_ERR_OUT,
   // Register file side and status
   input wire       WR_STB_OUT,
   input wire       RD_STB_OUT,
   input wire       ADDRESSED_OUT,
   input wire       BUSY_OUT
);
   // ********************************
   // Bus conditions and properties
   // ********************************
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   sequence s_start; SCL_IN && $fell(SDA_IN); endsequence
   sequence s_stop; SCL_IN && $rose(SDA_IN); endsequence
   a_start_sets_busy: assert property (s_start |-> ##[1:6] BUSY_OUT)
      else $error("busy missing after start");
   a_stop_clears_all: assert property (s_stop |-> ##[1:6] !BUSY_OUT && !ADDRESSED_OUT)
      else $error("decoder not cleared by stop");
   a_wr_needs_match: assert property (WR_STB_OUT |-> ADDRESSED_OUT && BUSY_OUT)
      else $error("write strobe while not addressed");
   a_wr_one_cycle: assert property (WR_STB_OUT |=> !WR_STB_OUT)
      else $error("write strobe too long");
   a_rd_one_cycle: assert property (RD_STB_OUT |-> ADDRESSED_OUT ##1 !RD_STB_OUT)
      else $error("read strobe wrong");
   a_drive_in_busy: assert property (SDA_OE_OUT |-> BUSY_OUT && !SDA_OUT)
      else $error("data driven outside transfer");
   a_spi_decode_ok: assert property (SPI_ADDR_VALID_IN |=>
      SPI_READ_OUT == $past(SPI_ADDR_BYTE_IN[7]) && SPI_REG_SEL_OUT == $past(SPI_ADDR_BYTE_IN[6:3])
      && SPI_CHANNEL_OUT == $past(SPI_ADDR_BYTE_IN[2:1])
      && SPI_CH_ERR_OUT == ($past(SPI_ADDR_BYTE_IN[2:1]) != 2'h0))
      else $error("address byte decode wrong");
   a_spi_fields_hold: assert property (!SPI_ADDR_VALID_IN |=> $stable({SPI_READ_OUT,
      SPI_REG_SEL_OUT, SPI_CHANNEL_OUT, SPI_CH_ERR_OUT}))
      else $error("decoded fields moved without strobe");
endmodule // shra_checker

//--- sim/shra_mst.sv
/* Two-wire bus master model driving clock and data.
   Assumes a pull-up on data and steps on the falling edge of clk_in. */
`timescale 1ns/100ps
module shra_mst (
   // Clock and device side
   input  wire clk_in,
   input  wire oe_in,
   input  wire sdo_in,
   // Bus lines
   output reg  scl_out,
   output wire sda_out
);
   reg mlow = 1'b0;
   initial scl_out = 1'b1;
   // Pull-up: released line reads high, never the last value
   assign sda_out = !(mlow || (oe_in && !sdo_in));
   task wt(input integer n);
      repeat (n) @(negedge clk_in);
   endtask
   // One 400 ns clock; data moves only while clock is low
   task bitx(input b, output s);
      begin
         wt(1);
         mlow = !b;
         wt(3);
         scl_out = 1'b1;
         wt(3);
         s = sda_out;
         wt(1);
         scl_out = 1'b0;
      end
   endtask
   task start;
      begin
         wt(1);
         mlow = 1'b0;
         wt(3);
         scl_out = 1'b1;
         wt(4);
         mlow = 1'b1;
         wt(4);
         scl_out = 1'b0;
      end
   endtask
   task stop;
      begin
         wt(1);
         mlow = 1'b1;
         wt(3);
         scl_out = 1'b1;
         wt(4);
         mlow = 1'b0;
         wt(6);
      end
   endtask
   task wbyte(input [7:0] b, output ack);
      integer i;
      reg s;
      begin
         for (i = 7; i >= 0; i = i - 1) bitx(b[i], s);
         bitx(1'b1, s);
         ack = !s;
      end
   endtask
   task rbyte(input nack, output [7:0] d);
      integer i;
      reg s;
      begin
         for (i = 7; i >= 0; i = i - 1) bitx(1'b1, d[i]);
         bitx(nack, s);
      end
   endtask
endmodule // shra_mst

//--- sim/shra_serial_host_register_access_tb.sv
/* Self-checking bench for the serial register access front end.
   Assumes the bus master model and the port checker beside it. */
`timescale 1ns/100ps
module shra_serial_host_register_access_tb;
   reg        clk = 1'b0, rstn = 1'b0, spi_v = 1'b0, ack;
   reg  [1:0] sh = 2'h0, sl = 2'h0;
   reg  [7:0] spi_b = 8'h00, d, last_wd;
   reg  [6:0] a;
   wire       scl, sda, sdo, oe, s_rd, s_err, wr, rd, adr, bsy;
   wire [3:0] s_reg, rsel;
   wire [1:0] s_ch, ch;
   wire [7:0] wd;
   integer    n_fail = 0, total_checks = 0, n_wr = 0, cyc = 0, h, l;
   always #25 clk = ~clk;
   shra_serial_host_register_access shra_serial_host_register_access_i (.CLK_IN(clk),
      .RESETN_IN(rstn), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sdo), .SDA_OE_OUT(oe),
      .ADDR_STRAP_HIGH_IN(sh), .ADDR_STRAP_LOW_IN(sl), .SPI_ADDR_VALID_IN(spi_v),
      .SPI_ADDR_BYTE_IN(spi_b), .SPI_READ_OUT(s_rd), .SPI_REG_SEL_OUT(s_reg),
      .SPI_CHANNEL_OUT(s_ch), .SPI_CH_ERR_OUT(s_err), .WR_STB_OUT(wr), .RD_STB_OUT(rd),
      .REG_SEL_OUT(rsel), .CHANNEL_OUT(ch), .WR_DATA_OUT(wd), .RD_DATA_IN({4'hA, rsel}),
      .ADDRESSED_OUT(adr), .BUSY_OUT(bsy));
   shra_mst shra_mst_i (.clk_in(clk), .oe_in(oe), .sdo_in(sdo), .scl_out(scl), .sda_out(sda));
   always @(posedge clk) if (wr === 1'b1) begin
      n_wr <= n_wr + 1;
      last_wd <= wd;
   end
   task chk(input string nm, input [7:0] seen, input [7:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task t_addr;
      begin
         for (h = 0; h < 4; h = h + 1) for (l = 0; l < 4; l = l + 1) begin
            sh = h;
            sl = l;
            a = 7'h48 + h * 4 + l;
            shra_mst_i.start;
            chk("busy", bsy, 1);
            shra_mst_i.wbyte({a, 1'b0}, ack);
            chk("ack", ack, 1);
            shra_mst_i.stop;
            chk("cleared", {bsy, adr}, 0);
         end
         shra_mst_i.start;
         shra_mst_i.wbyte({a ^ 7'h01, 1'b0}, ack);
         chk("foreign_ack", {ack, adr}, 0);
         shra_mst_i.stop;
         $display("t_addr done");
      end
   endtask
   task t_write;
      begin
         shra_mst_i.start;
         shra_mst_i.wbyte(8'hAC, ack);
         shra_mst_i.wbyte(8'hD1, ack);
         chk("sub_ack", ack, 1);
         chk("reg_sel", rsel, 8'h0A);
         shra_mst_i.wbyte(8'h3C, ack);
         shra_mst_i.wbyte(8'hC3, ack);
         chk("wr_count", n_wr, 2);
         chk("wr_data", last_wd, 8'hC3);
         chk("channel", ch, 0);
         shra_mst_i.stop;
         $display("t_write done");
      end
   endtask
   task t_read;
      begin
         shra_mst_i.start;
         shra_mst_i.wbyte(8'hAC, ack);
         shra_mst_i.wbyte(8'h19, ack);
         shra_mst_i.start;
         shra_mst_i.wbyte(8'hAD, ack);
         chk("rd_ack", ack, 1);
         shra_mst_i.rbyte(1'b0, d);
         chk("rd_first", d, 8'hA3);
         shra_mst_i.rbyte(1'b1, d);
         chk("rd_last", d, 8'hA3);
         shra_mst_i.stop;
         $display("t_read done");
      end
   endtask
   task t_spi(input [7:0] b, input [7:0] exp);
      begin
         spi_b = b;
         spi_v = 1'b1;
         @(negedge clk);
         spi_v = 1'b0;
         @(negedge clk);
         chk("spi_fields", {s_rd, s_reg, s_ch, s_err}, exp);
         $display("t_spi done");
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", total_checks, n_fail);
         if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         print_verdict;
      end
   end
   initial begin
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      t_addr;
      sh = 2'h3;
      sl = 2'h2;
      t_write;
      t_read;
      t_spi(8'hB8, 8'hB8);
      t_spi(8'h46, 8'h47);
      t_spi(8'h01, 8'h00);
      print_verdict;
   end
endmodule // shra_serial_host_register_access_tb
bind shra_serial_host_register_access shra_checker shra_checker_i (.CLK_IN(CLK_IN),
   .RESETN_IN(RESETN_IN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
   .SDA_OE_OUT(SDA_OE_OUT), .SPI_ADDR_VALID_IN(SPI_ADDR_VALID_IN),
   .SPI_ADDR_BYTE_IN(SPI_ADDR_BYTE_IN), .SPI_READ_OUT(SPI_READ_OUT),
   .SPI_REG_SEL_OUT(SPI_REG_SEL_OUT), .SPI_CHANNEL_OUT(SPI_CHANNEL_OUT),
   .SPI_CH_ERR_OUT(SPI_CH_ERR_OUT), .WR_STB_OUT(WR_STB_OUT), .RD_STB_OUT(RD_STB_OUT),
   .ADDRESSED_OUT(ADDRESSED_OUT), .BUSY_OUT(BUSY_OUT));
